// >>> hw/freq_pkg.sv
// constants, offsets and types shared by the frequency supervision block
`default_nettype none
package freq_pkg;
   // register map (byte addresses on the avalon slave)
   localparam logic [7:0] CTRL_OFS       = 8'h00;
   localparam logic [7:0] RATED_OFS      = 8'h04;
   localparam logic [7:0] UNOM_OFS       = 8'h08;
   localparam logic [7:0] MINCMD_OFS     = 8'h0c;
   localparam logic [7:0] STAGE_BASE_OFS = 8'h10;
   localparam logic [7:0] STAGE_END_OFS  = 8'h30;
   localparam logic [7:0] STATUS_OFS     = 8'h30;
   localparam logic [7:0] FREQ_OFS       = 8'h34;

   // field positions
   localparam int CTRL_EN_BIT     = 0;
   localparam int THR_MODE_LSB    = 17;
   localparam int ST_PICKUP_LSB   = 0;
   localparam int ST_TRIP_LSB     = 4;
   localparam int ST_VLOW_BIT     = 8;
   localparam int ST_RANGE_BIT    = 9;
   localparam int ST_OVERALL_BIT  = 10;

   // reset values
   localparam logic        CTRL_EN_RST = 1'b0;
   localparam logic [16:0] RATED_RST   = 17'd50000;
   localparam logic [15:0] UNOM_RST    = 16'd1000;
   localparam logic [15:0] MINCMD_RST  = 16'd100;
   localparam logic [16:0] THR_RST     = 17'd50000;
   localparam logic [19:0] DLY_RST     = 20'd0;

   // measurement limits, frequency in mHz, voltage in percent of nominal
   localparam logic [16:0] FREQ_MIN_MHZ  = 17'd25000;
   localparam logic [16:0] FREQ_MAX_MHZ  = 17'd70000;
   localparam logic [17:0] HYST_MHZ      = 18'd20;
   localparam logic [6:0]  VMIN_PCT      = 7'd65;
   localparam logic [6:0]  FULL_PCT      = 7'd100;
   localparam logic [2:0]  CONSEC_COUNT  = 3'd5;

   // timing: one delay tick per millisecond
   localparam int CLK_MHZ          = 50;
   localparam int DELAY_TICK_US    = 1000;
   localparam int DELAY_TICK_CYC   = CLK_MHZ * DELAY_TICK_US;

   typedef enum logic [1:0] {
      MODE_OFF   = 2'b00,
      MODE_TRIP  = 2'b01,
      MODE_ALARM = 2'b10
   } stage_mode_t;

   typedef enum logic [1:0] {
      ST_IDLE   = 2'b00,
      ST_PICKED = 2'b01
   } stage_state_t;

   typedef enum logic [1:0] {
      SLOPE_NONE = 2'b00,
      SLOPE_UP   = 2'b01,
      SLOPE_DOWN = 2'b11
   } slope_t;
endpackage : freq_pkg
`default_nettype wire

// >>> hw/freq_stage.sv
// one over/under frequency stage: pickup counting, hysteresis, delay and trip
`default_nettype none
module freq_stage
   import freq_pkg::*;
(
   input  wire logic                  i_clk_sys,
   input  wire logic                  i_rst_b,
   input  wire logic                  i_sample,
   input  wire logic [16:0]           i_freq,
   input  wire logic [16:0]           i_thr,
   input  wire logic [16:0]           i_rated,
   input  wire freq_pkg::stage_mode_t i_mode,
   input  wire logic [19:0]           i_delay,
   input  wire logic                  i_ms_tick,
   input  wire logic                  i_force_drop,
   output logic                       o_pickup,
   output logic                       o_trip
);
   stage_state_t state_ff;
   stage_state_t nxt_state;
   logic [2:0]   cnt_ff;
   logic [2:0]   nxt_cnt;
   logic [19:0]  timer_ff;
   logic [19:0]  nxt_timer;
   logic         trip_ff;
   logic         nxt_trip;

   // direction follows threshold against rated; equal means inactive
   wire logic        is_over  = i_thr > i_rated;
   wire logic        is_under = i_thr < i_rated;
   wire logic        active   = (i_mode != MODE_OFF) && (is_over || is_under);
   wire logic [17:0] thr_x    = {1'b0, i_thr};
   wire logic [17:0] freq_x   = {1'b0, i_freq};
   wire logic        beyond   = is_over ? (i_freq > i_thr) : (i_freq < i_thr);
   // hold band is 20 mHz wider than pickup, so small ripple cannot chatter
   wire logic        holding  = is_over ? (freq_x > (thr_x - HYST_MHZ))
                                        : (freq_x < (thr_x + HYST_MHZ));
   wire logic        kill     = i_force_drop || !active;

   // next state: five consecutive samples to pick up and to drop out
   always_comb begin
      nxt_state = state_ff;
      nxt_cnt   = cnt_ff;
      nxt_timer = timer_ff;
      if (kill) begin
         nxt_state = ST_IDLE;
         nxt_cnt   = 3'd0;
         nxt_timer = 20'd0;
      end else if (state_ff == ST_IDLE) begin
         nxt_timer = 20'd0;
         if (i_sample) begin
            // no warm-up gate: a first sample may already count
            nxt_cnt = beyond ? cnt_ff + 3'd1 : 3'd0;
            if (beyond && (cnt_ff + 3'd1 == CONSEC_COUNT)) begin
               nxt_state = ST_PICKED;
               nxt_cnt   = 3'd0;
            end
         end
      end else begin
         if (i_ms_tick && (timer_ff < i_delay)) begin
            nxt_timer = timer_ff + 20'd1;
         end
         if (i_sample) begin
            nxt_cnt = holding ? 3'd0 : cnt_ff + 3'd1;
            if (!holding && (cnt_ff + 3'd1 == CONSEC_COUNT)) begin
               nxt_state = ST_IDLE;
               nxt_cnt   = 3'd0;
               nxt_timer = 20'd0;
            end
         end
      end
   end

   // trip ends in the same edge as the dropout; alarm-only never trips
   assign nxt_trip = (nxt_state == ST_PICKED) && (nxt_timer >= i_delay)
                     && (i_mode == MODE_TRIP);

   always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         state_ff <= ST_IDLE;
         cnt_ff   <= 3'd0;
         timer_ff <= 20'd0;
         trip_ff  <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         cnt_ff   <= nxt_cnt;
         timer_ff <= nxt_timer;
         trip_ff  <= nxt_trip;
      end
   end

   assign o_pickup = (state_ff == ST_PICKED);
   assign o_trip   = trip_ff;
endmodule : freq_stage
`default_nettype wire

// >>> hw/freq_prot.sv
// four-stage frequency supervision with avalon-mm register slave
//
// Functional notes
// - four independent stages, own threshold and delay
// - threshold above rated over, below under
// - measure largest line voltage, gate below 65%
// - flag when all voltages below minimum
// - voltage loss after pickup drops the stage
// - reversed frequency slope sign discards sample
// - dropout hysteresis of 20 mHz
// - pickup after five consecutive beyond samples
// - evaluate 25 to 70 Hz, else drop
// - resume when frequency and voltage return
// - voltage off drops stages immediately
// - pickup starts delay, expiry issues trip
// - dropout after five consecutive failing samples
// - stage trip ends, overall trip held minimum
// - each stage blockable by binary input
// - one binary input blocks whole function
// - ready at once when voltage applied
// - stage modes off, trip, alarm only
// - global enable, otherwise inert
`default_nettype none
module freq_prot
   import freq_pkg::*;
#(
   parameter int MS_CYCLES = freq_pkg::DELAY_TICK_CYC
) (
   input  wire logic        i_clk_sys,
   input  wire logic        i_rst_b,
   input  wire logic [7:0]  i_address,
   input  wire logic        i_read,
   input  wire logic        i_write,
   input  wire logic [31:0] i_writedata,
   output logic [31:0]      o_readdata,
   output logic             o_waitrequest,
   input  wire logic        i_tick,
   input  wire logic [16:0] i_freq,
   input  wire logic [15:0] i_volt_ab,
   input  wire logic [15:0] i_volt_bc,
   input  wire logic [15:0] i_volt_ca,
   input  wire logic [3:0]  i_blk_stage,
   input  wire logic        i_blk_all,
   output logic [3:0]       o_pickup,
   output logic [3:0]       o_stage_trip,
   output logic             o_trip,
   output logic             o_meas_voltage_low_flag
);
   // largest of three magnitudes
   function automatic logic [15:0] max3(input logic [15:0] a, input logic [15:0] b,
                                        input logic [15:0] c);
      logic [15:0] m;
      m = (a > b) ? a : b;
      return (c > m) ? c : m;
   endfunction : max3

   // stage slot from a byte address inside the stage window
   function automatic logic [1:0] stage_idx(input logic [7:0] addr);
      return addr[4:3] + 2'd2;
   endfunction : stage_idx

   // configuration registers
   logic              en_ff;
   logic [16:0]       rated_ff;
   logic [15:0]       unom_ff;
   logic [15:0]       mincmd_ff;
   logic [16:0]       thr_ff  [4];
   stage_mode_t       mode_ff [4];
   logic [19:0]       dly_ff  [4];

   // bus state
   logic              wait_ff;
   logic [31:0]       rdata_ff;
   logic [31:0]       nxt_rdata;

   // pin synchronisers for the binary block inputs
   logic [4:0]        blk_meta_ff;
   logic [4:0]        blk_sync_ff;

   // measurement state
   logic [16:0]       prev_freq_ff;
   slope_t            prev_slope_ff;
   logic              range_bad_ff;
   logic              vlow_ff;
   logic [16:0]       last_freq_ff;

   // timing and overall trip
   logic [15:0]       ms_div_ff;
   logic              ms_tick_ff;
   logic [15:0]       hold_ff;
   logic              trip_ff;
   logic [3:0]        trip_prev_ff;

   logic [3:0]        pickup_w;
   logic [3:0]        stage_trip_w;

   // avalon decode: one wait cycle, then the access completes
   wire logic         req        = i_read || i_write;
   wire logic         done       = req && !wait_ff;
   wire logic         wr_go      = i_write && done;
   wire logic         in_stage   = (i_address >= STAGE_BASE_OFS) &&
                                   (i_address < STAGE_END_OFS);
   wire logic [1:0]   sidx       = stage_idx(i_address);
   wire logic         stage_thr  = in_stage && (i_address[2:0] == 3'd0);
   wire logic         stage_dly  = in_stage && (i_address[2:0] == 3'd4);

   // voltage gate: largest phase-phase value against 65 % of nominal
   wire logic [15:0]  vmax       = max3(i_volt_ab, i_volt_bc, i_volt_ca);
   wire logic [22:0]  vmax_pct   = vmax * FULL_PCT;
   wire logic [22:0]  vmin_pct   = unom_ff * VMIN_PCT;
   wire logic         volt_ok    = vmax_pct >= vmin_pct;

   // range and slope qualification of each half-period sample
   wire logic         in_range   = (i_freq >= FREQ_MIN_MHZ) && (i_freq <= FREQ_MAX_MHZ);
   wire slope_t       slope_now  = (i_freq > prev_freq_ff) ? SLOPE_UP :
                                   (i_freq < prev_freq_ff) ? SLOPE_DOWN : SLOPE_NONE;
   wire logic         jump       = (slope_now != SLOPE_NONE) &&
                                   (prev_slope_ff != SLOPE_NONE) &&
                                   (slope_now != prev_slope_ff);
   wire logic         tick_meas  = i_tick && en_ff && volt_ok && in_range;
   wire logic         sample_ok  = tick_meas && !jump;

   wire logic         blk_all    = blk_sync_ff[4];
   wire logic [3:0]   blk_stage  = blk_sync_ff[3:0];
   wire logic         range_drop = i_tick ? !in_range : range_bad_ff;
   wire logic         common_drop = !en_ff || blk_all || !volt_ok || range_drop;

   // overall trip holds for the minimum command time after any stage trip
   wire logic         any_trip   = |stage_trip_w;
   wire logic         new_trip   = |(stage_trip_w & ~trip_prev_ff);

   // read mux
   always_comb begin
      nxt_rdata = 32'h0000_0000;
      if (i_address == CTRL_OFS) begin
         nxt_rdata[CTRL_EN_BIT] = en_ff;
      end else if (i_address == RATED_OFS) begin
         nxt_rdata[16:0] = rated_ff;
      end else if (i_address == UNOM_OFS) begin
         nxt_rdata[15:0] = unom_ff;
      end else if (i_address == MINCMD_OFS) begin
         nxt_rdata[15:0] = mincmd_ff;
      end else if (stage_thr) begin
         nxt_rdata[16:0] = thr_ff[sidx];
         nxt_rdata[THR_MODE_LSB +: 2] = mode_ff[sidx];
      end else if (stage_dly) begin
         nxt_rdata[19:0] = dly_ff[sidx];
      end else if (i_address == STATUS_OFS) begin
         nxt_rdata[ST_PICKUP_LSB +: 4] = pickup_w;
         nxt_rdata[ST_TRIP_LSB +: 4]   = stage_trip_w;
         nxt_rdata[ST_VLOW_BIT]        = vlow_ff;
         nxt_rdata[ST_RANGE_BIT]       = range_bad_ff;
         nxt_rdata[ST_OVERALL_BIT]     = trip_ff;
      end else if (i_address == FREQ_OFS) begin
         nxt_rdata[16:0] = last_freq_ff;
      end
   end

   // bus handshake and read data capture
   always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         wait_ff  <= 1'b1;
         rdata_ff <= 32'h0000_0000;
      end else begin
         wait_ff  <= !(req && wait_ff);
         rdata_ff <= nxt_rdata;
      end
   end

   // software-written configuration, taken on the completing edge only
   always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         en_ff     <= CTRL_EN_RST;
         rated_ff  <= RATED_RST;
         unom_ff   <= UNOM_RST;
         mincmd_ff <= MINCMD_RST;
         for (int n = 0; n < 4; n++) begin
            thr_ff[n]  <= THR_RST;
            mode_ff[n] <= MODE_OFF;
            dly_ff[n]  <= DLY_RST;
         end
      end else if (wr_go) begin
         if (i_address == CTRL_OFS) begin
            en_ff <= i_writedata[CTRL_EN_BIT];
         end else if (i_address == RATED_OFS) begin
            rated_ff <= i_writedata[16:0];
         end else if (i_address == UNOM_OFS) begin
            unom_ff <= i_writedata[15:0];
         end else if (i_address == MINCMD_OFS) begin
            mincmd_ff <= i_writedata[15:0];
         end else if (stage_thr) begin
            thr_ff[sidx]  <= i_writedata[16:0];
            mode_ff[sidx] <= stage_mode_t'(i_writedata[THR_MODE_LSB +: 2]);
         end else if (stage_dly) begin
            dly_ff[sidx] <= i_writedata[19:0];
         end
      end
   end

   // two flip-flops on every binary block pin
   always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         blk_meta_ff <= 5'h00;
         blk_sync_ff <= 5'h00;
      end else begin
         blk_meta_ff <= {i_blk_all, i_blk_stage};
         blk_sync_ff <= blk_meta_ff;
      end
   end

   // slope history refreshed on every qualified tick, range state on every tick
   always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         prev_freq_ff  <= 17'd0;
         prev_slope_ff <= SLOPE_NONE;
         range_bad_ff  <= 1'b0;
         last_freq_ff  <= 17'd0;
      end else begin
         if (i_tick) begin
            range_bad_ff <= !in_range;
         end
         if (tick_meas) begin
            prev_freq_ff  <= i_freq;
            prev_slope_ff <= slope_now;
         end else if (!volt_ok) begin
            // history is stale once the voltage has gone
            prev_slope_ff <= SLOPE_NONE;
         end
         if (sample_ok) begin
            last_freq_ff <= i_freq;
         end
      end
   end

   // millisecond prescaler for the stage delays and command hold
   always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         ms_div_ff  <= 16'd0;
         ms_tick_ff <= 1'b0;
      end else if (ms_div_ff == 16'(MS_CYCLES - 1)) begin
         ms_div_ff  <= 16'd0;
         ms_tick_ff <= 1'b1;
      end else begin
         ms_div_ff  <= ms_div_ff + 16'd1;
         ms_tick_ff <= 1'b0;
      end
   end

   // the four stages
   for (genvar g = 0; g < 4; g++) begin : g_stage
      freq_stage u_stage (
         .i_clk_sys    (i_clk_sys),
         .i_rst_b      (i_rst_b),
         .i_sample     (sample_ok),
         .i_freq       (i_freq),
         .i_thr        (thr_ff[g]),
         .i_rated      (rated_ff),
         .i_mode       (mode_ff[g]),
         .i_delay      (dly_ff[g]),
         .i_ms_tick    (ms_tick_ff),
         .i_force_drop (common_drop || blk_stage[g]),
         .o_pickup     (pickup_w[g]),
         .o_trip       (stage_trip_w[g])
      );
   end

   // overall trip: stage trips or remaining minimum command time
   always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         hold_ff      <= 16'd0;
         trip_ff      <= 1'b0;
         trip_prev_ff <= 4'h0;
         vlow_ff      <= 1'b0;
      end else begin
         trip_prev_ff <= stage_trip_w;
         if (new_trip) begin
            hold_ff <= mincmd_ff;
         end else if (ms_tick_ff && (hold_ff != 16'd0)) begin
            hold_ff <= hold_ff - 16'd1;
         end
         trip_ff <= any_trip || new_trip || (hold_ff != 16'd0);
         vlow_ff <= en_ff && !volt_ok;
      end
   end

   assign o_readdata              = rdata_ff;
   assign o_waitrequest           = wait_ff;
   assign o_pickup                = pickup_w;
   assign o_stage_trip            = stage_trip_w;
   assign o_trip                  = trip_ff;
   assign o_meas_voltage_low_flag = vlow_ff;
endmodule : freq_prot
`default_nettype wire

// >>> testbench/freq_prot_monitor.sv
// assertion checker on the ports of the frequency supervision top
`default_nettype none
module freq_prot_monitor
   import freq_pkg::*;
(
   input wire logic        i_clk_sys,
   input wire logic        i_rst_b,
   input wire logic        i_read,
   input wire logic        i_write,
   input wire logic        o_waitrequest,
   input wire logic        i_tick,
   input wire logic [16:0] i_freq,
   input wire logic [15:0] i_volt_ab,
   input wire logic [15:0] i_volt_bc,
   input wire logic [15:0] i_volt_ca,
   input wire logic [3:0]  i_blk_stage,
   input wire logic        i_blk_all,
   input wire logic [3:0]  o_pickup,
   input wire logic [3:0]  o_stage_trip,
   input wire logic        o_trip,
   input wire logic        o_meas_voltage_low_flag
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (!i_rst_b);

   // bus answer: one wait state, ready one cycle
   sequence s_req; (i_read || i_write) && o_waitrequest; endsequence
   sequence s_ans; !o_waitrequest ##1 o_waitrequest; endsequence
   sequence s_volt_gone;
      ((i_volt_ab | i_volt_bc | i_volt_ca) == 16'h0) [*3];
   endsequence

   property p_bus_wait; s_req |=> s_ans; endproperty
   property p_blk_stage;
      ((o_pickup | o_stage_trip) & $past(i_blk_stage, 1) & $past(i_blk_stage, 2)
       & $past(i_blk_stage, 3)) == 4'h0;
   endproperty
   property p_blk_all; i_blk_all [*3] |=> (o_pickup | o_stage_trip) == 4'h0; endproperty
   property p_trip_pick; (o_stage_trip & ~o_pickup) == 4'h0; endproperty
   property p_trip_follow; $rose(|o_stage_trip) |-> ##[0:1] o_trip; endproperty
   property p_trip_cause; $rose(o_trip) |-> (|o_stage_trip) || (|$past(o_stage_trip)); endproperty
   property p_pick_tick; |(o_pickup & ~$past(o_pickup)) |-> $past(i_tick); endproperty
   property p_volt_off; s_volt_gone |=> o_pickup == 4'h0; endproperty
   property p_range;
      i_tick && (i_freq < FREQ_MIN_MHZ || i_freq > FREQ_MAX_MHZ) |-> ##2 o_pickup == 4'h0;
   endproperty
   property p_vlow; o_meas_voltage_low_flag |-> !o_pickup; endproperty

   a_bus_wait: assert property (p_bus_wait) else $error("bus wait state wrong");
   a_blk_stage: assert property (p_blk_stage) else $error("blocked stage active");
   a_blk_all: assert property (p_blk_all) else $error("global block ignored");
   a_trip_pick: assert property (p_trip_pick) else $error("trip without pickup");
   a_trip_follow: assert property (p_trip_follow) else $error("no overall trip");
   a_trip_cause: assert property (p_trip_cause) else $error("overall trip uncaused");
   a_pick_tick: assert property (p_pick_tick) else $error("pickup without sample");
   a_volt_off: assert property (p_volt_off) else $error("pickup with no voltage");
   a_range: assert property (p_range) else $error("pickup out of range");
   a_vlow: assert property (p_vlow) else $error("pickup at low voltage");
endmodule : freq_prot_monitor
`default_nettype wire

// >>> testbench/freq_front_end.sv
// far side model: line voltages, frequency samples and block pins
`default_nettype none
module freq_front_end (
   input  wire logic        i_clk_sys,
   output logic             o_tick,
   output logic [16:0]      o_freq,
   output logic [15:0]      o_volt_ab,
   output logic [15:0]      o_volt_bc,
   output logic [15:0]      o_volt_ca,
   output logic [3:0]       o_blk_stage,
   output logic             o_blk_all
);
   timeunit 1ns;
   timeprecision 1ns;
   int          seed = 62;
   logic [15:0] lvl = 16'h0;

   initial begin
      o_tick = 1'b0;
      o_freq = 17'h0;
      o_volt_ab = 16'h0;
      o_volt_bc = 16'h0;
      o_volt_ca = 16'h0;
      o_blk_stage = 4'h0;
      o_blk_all = 1'b0;
   end

   // one random phase at the level, two below it
   task automatic spread();
      logic [15:0] a;
      logic [15:0] b;
      a = (lvl == 16'h0) ? 16'h0 : 16'($unsigned($random(seed)) % lvl);
      b = (lvl == 16'h0) ? 16'h0 : 16'($unsigned($random(seed)) % lvl);
      case ($unsigned($random(seed)) % 3)
         0: begin o_volt_ab <= lvl; o_volt_bc <= a; o_volt_ca <= b; end
         1: begin o_volt_ab <= a; o_volt_bc <= lvl; o_volt_ca <= b; end
         default: begin o_volt_ab <= a; o_volt_bc <= b; o_volt_ca <= lvl; end
      endcase
   endtask : spread

   task automatic set_level(input logic [15:0] v);
      @(posedge i_clk_sys);
      lvl = v;
      spread();
   endtask : set_level

   // data inverted between strobes, so stale values never pass
   task automatic send_tick(input logic [16:0] f);
      @(posedge i_clk_sys);
      spread();
      o_tick <= 1'b1;
      o_freq <= f;
      @(posedge i_clk_sys);
      o_tick <= 1'b0;
      o_freq <= ~f;
      repeat (2) @(posedge i_clk_sys);
   endtask : send_tick

   // block pins, held past the two-flop sync
   task automatic set_block(input logic [3:0] s, input logic a);
      @(posedge i_clk_sys);
      o_blk_stage <= s;
      o_blk_all <= a;
      repeat (2) @(posedge i_clk_sys);
   endtask : set_block
endmodule : freq_front_end
`default_nettype wire

// >>> testbench/tb_freq_prot.sv
// self-checking bench for the frequency supervision block
`default_nettype none
module tb_freq_prot;
   timeunit 1ns;
   timeprecision 1ns;
   import freq_pkg::*;
   localparam int MS = 10;
   logic        clk;
   logic        rst_b;
   logic [7:0]  addr;
   logic        rd;
   logic        wr;
   logic [31:0] wdata;
   logic [31:0] rdata;
   logic        wreq;
   logic        tick;
   logic [16:0] freq;
   logic [15:0] va;
   logic [15:0] vb;
   logic [15:0] vc;
   logic [3:0]  blk;
   logic        blk_all;
   logic [3:0]  pk;
   logic [3:0]  st;
   logic        trip;
   logic        vlow;
   logic [31:0] rd_q[$];
   logic [3:0]  pk_q[$];
   logic [3:0]  pk_prev = 4'h0;
   int          err_count = 0;
   int          tests_run = 0;

   freq_prot #(.MS_CYCLES(MS)) dut (.i_clk_sys(clk), .i_rst_b(rst_b), .i_address(addr),
      .i_read(rd), .i_write(wr), .i_writedata(wdata), .o_readdata(rdata),
      .o_waitrequest(wreq), .i_tick(tick), .i_freq(freq), .i_volt_ab(va), .i_volt_bc(vb),
      .i_volt_ca(vc), .i_blk_stage(blk), .i_blk_all(blk_all), .o_pickup(pk),
      .o_stage_trip(st), .o_trip(trip), .o_meas_voltage_low_flag(vlow));
   freq_front_end fe (.i_clk_sys(clk), .o_tick(tick), .o_freq(freq), .o_volt_ab(va),
      .o_volt_bc(vb), .o_volt_ca(vc), .o_blk_stage(blk), .o_blk_all(blk_all));

   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : complete_run

   task automatic timeout();
      err_count++;
      $display("BAD wait expected done seen timeout");
      complete_run();
   endtask : timeout

   task automatic chk_rd(input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         err_count++;
         $display("BAD readdata expected %h seen %h", exp, got);
      end
   endtask : chk_rd

   task automatic chk_pk(input logic [3:0] exp, input logic [3:0] got);
      tests_run++;
      if (got !== exp) begin
         err_count++;
         $display("BAD pickup expected %h seen %h", exp, got);
      end
   endtask : chk_pk

   // request held until ready is sampled low, then released
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      addr <= a;
      wdata <= d;
      rd <= !w;
      wr <= w;
      for (n = 0; n < 20; n++) begin
         @(posedge clk);
         if (!wreq) break;
      end
      if (n == 20) timeout();
      rd <= 1'b0;
      wr <= 1'b0;
   endtask : bus

   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask : wr_reg

   task automatic rd_exp(input logic [7:0] a, input logic [31:0] e);
      rd_q.push_back(e);
      bus(1'b0, a, 32'h0);
   endtask : rd_exp

   function automatic logic [31:0] thr_word(input stage_mode_t m, input logic [16:0] t);
      return (32'(m) << THR_MODE_LSB) | 32'(t);
   endfunction : thr_word

   task automatic cfg(input int n, input stage_mode_t m, input logic [16:0] t,
                      input logic [19:0] d);
      wr_reg(STAGE_BASE_OFS + 8'(8 * n), thr_word(m, t));
      wr_reg(STAGE_BASE_OFS + 8'(8 * n + 4), 32'(d));
   endtask : cfg

   task automatic ticks(input int k, input logic [16:0] f);
      repeat (k) fe.send_tick(f);
   endtask : ticks

   task automatic wait_pk();
      int n;
      for (n = 0; n < 300 && pk_q.size() != 0; n++) @(posedge clk);
      if (pk_q.size() != 0) timeout();
   endtask : wait_pk

   // watchers take the oldest note per answer
   always @(posedge clk) begin
      if (rd && !wreq && rd_q.size() != 0) chk_rd(rd_q.pop_front(), rdata);
      if (rst_b && pk !== pk_prev) chk_pk(pk_q.size() ? pk_q.pop_front() : pk_prev, pk);
      pk_prev = pk;
   end

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   initial begin
      rst_b = 1'b0;
      addr = 8'h0;
      rd = 1'b0;
      wr = 1'b0;
      wdata = 32'h0;
      repeat (16) @(posedge clk);
      rst_b <= 1'b1;
      // reset values, then an unmapped word
      rd_exp(CTRL_OFS, 32'h0);
      rd_exp(RATED_OFS, 32'(RATED_RST));
      rd_exp(UNOM_OFS, 32'(UNOM_RST));
      rd_exp(MINCMD_OFS, 32'(MINCMD_RST));
      rd_exp(STAGE_BASE_OFS, 32'(THR_RST));
      wr_reg(8'h38, 32'hffff_ffff);
      rd_exp(8'h38, 32'h0);
      fe.set_level(16'h3e8);
      wr_reg(MINCMD_OFS, 32'h14);
      cfg(0, MODE_TRIP, 17'hc738, 20'h2);
      cfg(1, MODE_ALARM, 17'hbf68, 20'h0);
      cfg(2, MODE_TRIP, 17'hc350, 20'h0);
      cfg(3, MODE_OFF, 17'hc738, 20'h0);
      rd_exp(STAGE_BASE_OFS + 8'h08, thr_word(MODE_ALARM, 17'hbf68));
      wr_reg(CTRL_OFS, 32'h1);
      // 51.5 Hz: the fifth sample picks up stage one only
      ticks(4, 17'hc92c);
      pk_q.push_back(4'h1);
      ticks(1, 17'hc92c);
      wait_pk();
      repeat (50) @(posedge clk);
      rd_exp(STATUS_OFS, 32'h411);
      // thr-19 mHz still holds, thr-20 mHz releases after five samples
      ticks(5, 17'hc725);
      ticks(4, 17'hc724);
      pk_q.push_back(4'h0);
      ticks(1, 17'hc724);
      wait_pk();
      rd_exp(STATUS_OFS, 32'h400);
      repeat (300) @(posedge clk);
      rd_exp(STATUS_OFS, 32'h0);
      // 48.9 Hz: alarm-only under stage picks up but never trips
      ticks(4, 17'hbf04);
      pk_q.push_back(4'h2);
      ticks(1, 17'hbf04);
      wait_pk();
      repeat (50) @(posedge clk);
      rd_exp(STATUS_OFS, 32'h002);
      // a jump back up reverses the slope and is thrown away
      ticks(1, 17'hbea0);
      ticks(1, 17'hc15c);
      rd_exp(FREQ_OFS, 32'hbea0);
      // voltage just under the minimum, then switched off
      pk_q.push_back(4'h0);
      fe.set_level(16'h289);
      wait_pk();
      rd_exp(STATUS_OFS, 32'h100);
      fe.set_level(16'h0);
      repeat (6) @(posedge clk);
      fe.set_level(16'h3e8);
      pk_q.push_back(4'h2);
      ticks(5, 17'hbf04);
      wait_pk();
      // a sample beyond 70 Hz drops the stage, an in-range one resumes
      pk_q.push_back(4'h0);
      ticks(1, 17'h11558);
      wait_pk();
      rd_exp(STATUS_OFS, 32'h200);
      pk_q.push_back(4'h2);
      ticks(5, 17'hbf04);
      wait_pk();
      // single stage block, then the whole function
      pk_q.push_back(4'h0);
      fe.set_block(4'h2, 1'b0);
      wait_pk();
      ticks(5, 17'hbf04);
      pk_q.push_back(4'h2);
      fe.set_block(4'h0, 1'b0);
      ticks(5, 17'hbf04);
      wait_pk();
      pk_q.push_back(4'h0);
      fe.set_block(4'h0, 1'b1);
      wait_pk();
      ticks(2, 17'hbf04);
      pk_q.push_back(4'h2);
      fe.set_block(4'h0, 1'b0);
      ticks(5, 17'hbf04);
      wait_pk();
      // disabling leaves the function inert
      pk_q.push_back(4'h0);
      wr_reg(CTRL_OFS, 32'h0);
      wait_pk();
      ticks(5, 17'hbf04);
      rd_exp(STATUS_OFS, 32'h0);
      complete_run();
   end
endmodule : tb_freq_prot

bind freq_prot freq_prot_monitor mon (.i_clk_sys, .i_rst_b, .i_read, .i_write,
   .o_waitrequest, .i_tick, .i_freq, .i_volt_ab, .i_volt_bc, .i_volt_ca, .i_blk_stage,
   .i_blk_all, .o_pickup, .o_stage_trip, .o_trip, .o_meas_voltage_low_flag);
`default_nettype wire
